// ---- design/wdt_defs.vh ----
// Constants and functional notes for the watchdog compare timer.
// Functional notes
// - The counter advances only on overflow pulses of the basic interval timer.
// - A match of the 7-bit counter with the low seven compare bits sets the flag.
// - A match either resets the CPU or only requests an interrupt, per the enable bit and the disable code register.
// - With the reset enable bit at 0 the unit is a plain 7-bit interval timer.
// - Without fault detection the counter gives interrupts at fixed intervals.
// - With the reset enable bit at 1, the CPU reset is suppressed only while the disable code register holds 8'ha5.
// - The disable code register reads zero after chip reset.
// - The reset enable bit is one after chip reset.
// - Writing one to the clear bit zeroes the counter; hardware drops it after one cycle.
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH
`define WDT_ADDR_COMPARE      8'hf4
`define WDT_ADDR_DISABLE      8'hf6
`define WDT_ADDR_CTRL         8'hf8
`define WDT_ADDR_STATUS       8'hfa
`define WDT_ADDR_MASK         8'hfc
`define WDT_COMPARE_RESET     8'h7f
`define WDT_DISABLE_RESET     8'h00
`define WDT_CTRL_RESET        8'h01
`define WDT_MASK_RESET        8'h00
`define WDT_DISABLE_CODE      8'ha5
`define WDT_CLEAR_BIT         7
`define WDT_CTRL_EN_BIT       0
`define WDT_ST_MATCH_BIT      0
`define WDT_ST_RESET_BIT      1
`define WDT_RESET_PULSE_CYC   4'h8
`endif

// ---- design/wdt_sync.v ----
// Two flip-flop synchroniser for the external advance pulse.
`timescale 1ns/10ps
module wdt_sync (
    input  wire clk,
    input  wire resetn,
    input  wire din,
    output reg  dout
);
    reg meta_q;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// ---- design/wdt_counter.v ----
// Seven-bit watchdog counter with compare and clear.
`timescale 1ns/10ps
module wdt_counter #(
    parameter W = 7
) (
    input  wire         clk,
    input  wire         resetn,
    input  wire         tick,
    input  wire         clear,
    input  wire [W-1:0] cmp,
    output reg  [W-1:0] count_q,
    output reg          match_q
);
    wire hit;
    // A match is seen only on an advance pulse, so one compare gives one event.
    assign hit = tick && (count_q == cmp);
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= {W{1'b0}};
            match_q <= 1'b0;
        end else begin
            match_q <= hit && !clear;
            if (clear) begin
                count_q <= {W{1'b0}};
            end else if (hit) begin
                count_q <= {W{1'b0}};
            end else if (tick) begin
                count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

// ---- design/watchdog_compare_timer.v ----
// Watchdog compare timer with its Wishbone register slave.
`timescale 1ns/10ps
`include "wdt_defs.vh"
module watchdog_compare_timer #(
    parameter RST_CYC = `WDT_RESET_PULSE_CYC
) (
    input  wire       clk,
    input  wire       resetn,
    input  wire       bit_overflow,
    input  wire       wb_cyc_i,
    input  wire       wb_stb_i,
    input  wire       wb_we_i,
    input  wire [7:0] wb_adr_i,
    input  wire [7:0] wb_dat_i,
    input  wire [0:0] wb_sel_i,
    output reg  [7:0] wb_dat_o,
    output reg        wb_ack_o,
    output reg        irq,
    output reg        cpu_reset
);
    reg  [7:0] watchdog_compare_reg_q;
    reg  [7:0] watchdog_disable_code_reg_q;
    reg        watchdog_reset_enable_q;
    reg  [1:0] status_q;
    reg  [1:0] mask_q;
    reg  [3:0] rst_cnt_q;
    reg  [7:0] rd_d;
    wire       tick;
    wire       match;
    wire [6:0] count;
    wire       wr;
    wire       rst_evt;
    wire       watchdog_counter_clear;
    wire [6:0] watchdog_compare_value;

    // The interval timer pulse comes from a separate block and is resynced.
    wdt_sync u_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    (bit_overflow),
        .dout   (tick)
    );

    assign watchdog_counter_clear = watchdog_compare_reg_q[`WDT_CLEAR_BIT];
    assign watchdog_compare_value = watchdog_compare_reg_q[6:0];

    wdt_counter #(
        .W (7)
    ) u_cnt (
        .clk     (clk),
        .resetn  (resetn),
        .tick    (tick),
        .clear   (watchdog_counter_clear),
        .cmp     (watchdog_compare_value),
        .count_q (count),
        .match_q (match)
    );

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    // The CPU reset needs the enable bit and a disable code other than a5.
    assign rst_evt = match && watchdog_reset_enable_q &&
        (watchdog_disable_code_reg_q != `WDT_DISABLE_CODE);

    function is_addr;
        input [7:0] a;
        input [7:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            watchdog_compare_reg_q      <= `WDT_COMPARE_RESET;
            watchdog_disable_code_reg_q <= `WDT_DISABLE_RESET;
            watchdog_reset_enable_q     <= 1'b1;
            mask_q                      <= 2'h0;
        end else begin
            if (watchdog_counter_clear) begin
                watchdog_compare_reg_q[`WDT_CLEAR_BIT] <= 1'b0;
            end
            if (wr && is_addr(wb_adr_i, `WDT_ADDR_COMPARE)) begin
                watchdog_compare_reg_q <= wb_dat_i;
            end
            if (wr && is_addr(wb_adr_i, `WDT_ADDR_DISABLE)) begin
                watchdog_disable_code_reg_q <= wb_dat_i;
            end
            if (wr && is_addr(wb_adr_i, `WDT_ADDR_CTRL)) begin
                // Zero turns the unit into a plain interval timer.
                watchdog_reset_enable_q <= wb_dat_i[`WDT_CTRL_EN_BIT];
            end
            if (wr && is_addr(wb_adr_i, `WDT_ADDR_MASK)) begin
                mask_q <= wb_dat_i[1:0];
            end
        end
    end

    // Hardware set wins over a software clear in the same cycle.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_q <= 2'h0;
        end else begin
            if (wr && is_addr(wb_adr_i, `WDT_ADDR_STATUS)) begin
                status_q <= (status_q & ~wb_dat_i[1:0]) |
                    {rst_evt, match};
            end else begin
                status_q <= status_q | {rst_evt, match};
            end
        end
    end

    // The reset pulse is stretched so the CPU core sees it for several cycles.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_cnt_q <= 4'h0;
            cpu_reset <= 1'b0;
            irq       <= 1'b0;
        end else begin
            if (rst_evt) begin
                rst_cnt_q <= RST_CYC[3:0];
            end else if (rst_cnt_q != 4'h0) begin
                rst_cnt_q <= rst_cnt_q - 4'h1;
            end
            cpu_reset <= rst_evt || (rst_cnt_q > 4'h1);
            irq       <= |(status_q & mask_q);
        end
    end

    always @* begin
        rd_d = 8'h00;
        case (wb_adr_i)
            `WDT_ADDR_COMPARE: rd_d = watchdog_compare_reg_q;
            `WDT_ADDR_DISABLE: rd_d = watchdog_disable_code_reg_q;
            `WDT_ADDR_CTRL:    rd_d = {count, watchdog_reset_enable_q};
            `WDT_ADDR_STATUS:  rd_d = {6'h00, status_q};
            `WDT_ADDR_MASK:    rd_d = {6'h00, mask_q};
            default:           rd_d = 8'h00;
        endcase
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 8'h00;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                wb_dat_o <= rd_d;
            end
        end
    end
endmodule

// ---- tb/wdt_monitor.sv ----
// Port checker for the watchdog compare timer.
`timescale 1ns/10ps
module wdt_monitor (
    input wire       clk,
    input wire       resetn,
    input wire       bit_overflow,
    input wire       wb_cyc_i,
    input wire       wb_stb_i,
    input wire       wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [7:0] wb_dat_o,
    input wire       wb_ack_o,
    input wire       cpu_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire       req = wb_cyc_i & wb_stb_i;
    logic [3:0] since_q;
    // Saturates so a long quiet spell never wraps back to a small age.
    always @(posedge clk) since_q <= bit_overflow ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
    a_ack_after_req: assert property (req && !wb_ack_o |=> wb_ack_o) else $error("late ack");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    a_ack_has_req: assert property (wb_ack_o |-> $past(req)) else $error("stray ack");
    a_ack_idle: assert property (!req |=> !wb_ack_o) else $error("idle ack");
    a_unmapped_zero: assert property (req && !wb_ack_o && !wb_we_i && wb_adr_i == 8'h00
        |=> wb_dat_o == 8'h00) else $error("unmapped read");
    a_data_hold: assert property (!req |=> $stable(wb_dat_o)) else $error("data moved");
    a_reset_len: assert property ($rose(cpu_reset) |-> cpu_reset[*8] ##1 !cpu_reset)
        else $error("reset width");
    a_reset_cause: assert property ($rose(cpu_reset) |-> since_q < 4'h8)
        else $error("reset without tick");
endmodule
bind watchdog_compare_timer wdt_monitor wdt_monitor_inst (.*);

// ---- tb/cpu_core_model.sv ----
// CPU core model that counts the watchdog resets it receives.
`timescale 1ns/10ps
module cpu_core_model (
    input wire clk,
    input wire cpu_reset,
    output int resets
);
    logic reset_q = 1'b0;
    initial resets = 0;
    always @(posedge clk) begin
        reset_q <= cpu_reset;
        if (cpu_reset && !reset_q) resets <= resets + 1;
    end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the watchdog compare timer.
`timescale 1ns/10ps
module tb;
    logic       clk = 0, resetn = 0, ovf = 0, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 8'h00, wdat = 8'h00, rd, c;
    wire  [7:0] dat_o;
    wire        ack, irq, cpu_reset;
    int         miscompares = 0, tests_run = 0, resets;
    always #4 clk = ~clk;
    watchdog_compare_timer watchdog_compare_timer_inst (.clk(clk), .resetn(resetn),
        .bit_overflow(ovf), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(1'b1), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .irq(irq), .cpu_reset(cpu_reset));
    cpu_core_model cpu_core_model_inst (.clk(clk), .cpu_reset(cpu_reset), .resets(resets));
    function logic [7:0] st_exp(input logic en, input logic [7:0] code);
        return {6'h00, en && code != 8'ha5, 1'b1};
    endfunction
    task chk(input string n, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, d);
        int n;
        n = 0;
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do @(posedge clk); while (ack !== 1'b1 && ++n < 50);
        if (ack !== 1'b1) begin
            miscompares++;
            $display("[FAIL] ack expected 1 seen %b", ack);
        end
        rd = dat_o;
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask
    task rdchk(input string n, input logic [7:0] a, e);
        wb(1'b0, a, 8'h00);
        chk(n, e, rd);
    endtask
    // One-cycle pulses: a longer pulse would advance the counter once per cycle.
    task tick(input int n);
        repeat (n) begin
            ovf <= 1'b1;
            @(posedge clk);
            ovf <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (8) @(posedge clk);
    endtask
    task summarize;
        $display("counts: %0d run, %0d miscompares", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        summarize;
    end
    initial begin
        logic       en;
        logic [7:0] code;
        int         r0;
        c = 8'($urandom(1));
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        rdchk("compare", 8'hf4, 8'h7f);
        rdchk("code", 8'hf6, 8'h00);
        rdchk("ctrl", 8'hf8, 8'h01);
        rdchk("unmapped", 8'h00, 8'h00);
        wb(1'b1, 8'hfc, 8'h03);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            en = i[0];
            code = i[1] ? 8'ha5 : 8'($urandom) & 8'h7f;
            c = 8'($urandom_range(4, 1));
            r0 = resets;
            wb(1'b1, 8'hf8, {7'h00, en});
            wb(1'b1, 8'hf6, code);
            wb(1'b1, 8'hf4, 8'h80 | c);
            rdchk("cleared", 8'hf8, {7'h00, en});
            tick(c);
            rdchk("count", 8'hf8, {c[6:0], en});
            chk("irq early", 8'h00, {7'h00, irq});
            tick(1);
            rdchk("status", 8'hfa, st_exp(en, code));
            rdchk("wrapped", 8'hf8, {7'h00, en});
            chk("irq", 8'h01, {7'h00, irq});
            chk("resets", st_exp(en, code) >> 1, 8'(resets - r0));
            wb(1'b1, 8'hfa, 8'hff);
            chk("irq cleared", 8'h00, {7'h00, irq});
            $display("test mode %0d done", i);
        end
        summarize;
    end
endmodule
